// file: design/scpcr_pkg.sv
// Package of constants and types for the smart card function configuration registers
// What this block does
// - Bridge-support extension byte at 4Ah is read-only and always reads zero.
// - Power-management data byte at 4Bh reads zero and ignores writes.
// - General control at 4Ch resets to zero; bits 7 and 3:0 read zero.
// - Bits 6:5 pick interrupt output A to D and program the interrupt pin.
// - Any asserted interrupt strap pin overrides the bits 6:5 selection.
// - General control bit 4 sets or clears the cold-state wake support flag.
// - Interrupt select and cold wake bits clear only on global hard reset.
// - Alias bits 31:16 at 50h supply the board device field read at 2Eh.
// - Alias bits 15:0 supply the board vendor field at 2Ch; resets to zero.
// - Socket configuration at 58h resets to 00110001h, by hard reset only.
// - Bit 24 set lets socket 0 accept class B cards; resets to 0.
// - Bit 20 set lets socket 0 accept class A cards; resets to 1.
// - Bit 16 enables the payment-card interface of socket 0; resets to 1.
// - Bit 12 enables the auxiliary card I/O pins of socket 0; resets to 0.
// - Bit 4 set makes socket 0 card insertion raise a wake event.
// - Bit 0 set makes socket 0 operational; resets to 1.
// - Socket bits 31:28 writable reserved; other unused bits read zero.
// - Auxiliary current reads 000b with cold wake clear, 001b when set.
package scpcr_pkg;

    // Configuration byte offsets
    localparam logic [7:0] OFS_BOARD_IDS = 8'h2c;
    localparam logic [7:0] OFS_PM_DWORD = 8'h48;
    localparam logic [7:0] OFS_PM_BRIDGE_EXT = 8'h4a;
    localparam logic [7:0] OFS_PM_DATA = 8'h4b;
    localparam logic [7:0] OFS_GEN_CTRL = 8'h4c;
    localparam logic [7:0] OFS_ALIAS = 8'h50;
    localparam logic [7:0] OFS_SOCKET = 8'h58;

    // General control layout
    localparam logic [7:0] GEN_CTRL_RESET = 8'h00;
    localparam logic [7:0] GEN_CTRL_WMASK = 8'h70;
    localparam int GEN_INT_SEL_LSB = 5;
    localparam int GEN_COLD_WAKE_BIT = 4;

    // Subsystem alias layout
    localparam logic [31:0] ALIAS_RESET = 32'h0000_0000;
    localparam int ALIAS_DEVICE_LSB = 16;
    localparam int ALIAS_VENDOR_LSB = 0;

    // Socket configuration layout
    localparam logic [31:0] SOCKET_RESET = 32'h0011_0001;
    localparam logic [31:0] SOCKET_WMASK = 32'hf111_1011;
    localparam int SOCK_CLASS_B_BIT = 24;
    localparam int SOCK_CLASS_A_BIT = 20;
    localparam int SOCK_PAY_IF_BIT = 16;
    localparam int SOCK_AUX_IO_BIT = 12;
    localparam int SOCK_INS_WAKE_BIT = 4;
    localparam int SOCK_ENABLE_BIT = 0;

    // Capability side values
    localparam logic [2:0] AUX_CURRENT_SELF = 3'h0;
    localparam logic [2:0] AUX_CURRENT_55MA = 3'h1;
    localparam logic [7:0] INT_PIN_BASE = 8'h01;

    // Number of interrupt strap pins
    localparam int STRAP_COUNT = 4;

    // One configuration cycle as seen at the function
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [3:0] be;
        logic [31:0] wdata;
    } scpcr_cfg_req_s;

    // Answer to a configuration cycle
    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
    } scpcr_cfg_rsp_s;

endpackage

// file: design/scpcr_pin_sync.sv
// Three-stage pin synchroniser with agreement filter, one lane per bit
`timescale 1ns/100ps
`default_nettype none
module scpcr_pin_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Pins and filtered levels
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] level_out
);

    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_lane
            logic ff1;
            logic ff2;
            logic ff3;
            logic level;
            logic next_level;

            // Accept a change only once stages two and three agree
            always_comb begin
                next_level = (ff2 == ff3) ? ff3 : level;
            end

            // First stage feeds only the second one
            always_ff @(posedge clk_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    ff1 <= 1'b0;
                    ff2 <= 1'b0;
                    ff3 <= 1'b0;
                    level <= 1'b0;
                end else begin
                    ff1 <= pin_in[g];
                    ff2 <= ff1;
                    ff3 <= ff2;
                    level <= next_level;
                end
            end

            assign level_out[g] = level;
        end
    endgenerate

endmodule
`default_nettype wire

// file: design/scpcr_insert_wake.sv
// Card insertion edge detector raising a one-cycle wake request
`timescale 1ns/100ps
`default_nettype none
module scpcr_insert_wake (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Filtered card presence and enable
    input wire logic present_in,
    input wire logic wake_enable_in,
    // Wake request pulse
    output logic wake_out
);

    logic present_q;
    logic wake;
    logic next_wake;

    // Rising presence is an insertion; gated by the socket wake bit
    always_comb begin
        next_wake = present_in && !present_q && wake_enable_in;
    end

    // Present history and registered pulse
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            present_q <= 1'b0;
            wake <= 1'b0;
        end else begin
            present_q <= present_in;
            wake <= next_wake;
        end
    end

    assign wake_out = wake;

    a_wake_on_insert: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (present_in && !present_q && wake_enable_in) |=> wake_out)
        else $error("insertion with wake enabled gave no wake pulse");
    a_wake_needs_enable: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        wake_out |-> $past(wake_enable_in) && $past(present_in))
        else $error("wake pulse without enable or insertion");
    c_wake_seen: cover property (@(posedge clk_in) disable iff (!rst_n_in) wake_out);

endmodule
`default_nettype wire

// file: design/scpcr_top.sv
// Smart card function configuration registers: decode, storage and side outputs
`timescale 1ns/100ps
`default_nettype none
module scpcr_top
    import scpcr_pkg::*;
(
    // Clock and global hard reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Configuration cycles from the host bus
    input wire scpcr_cfg_req_s cfg_req_in,
    output scpcr_cfg_rsp_s cfg_rsp_out,
    // Pins from the board
    input wire logic [STRAP_COUNT-1:0] interrupt_strap_pins_in,
    input wire logic card_present_in,
    // Interrupt routing
    output logic [1:0] int_route_out,
    output logic [7:0] interrupt_pin_reg_out,
    // Power management capability fields
    output logic cold_wake_flag_out,
    output logic [2:0] aux_current_out,
    output logic pme_wake_out,
    // Aliased board identifiers
    output logic [15:0] board_vendor_field_out,
    output logic [15:0] board_device_field_out,
    // Socket 0 controls
    output logic slot0_enable_out,
    output logic slot0_class_a_support_out,
    output logic slot0_class_b_support_out,
    output logic slot0_payment_iface_enable_out,
    output logic slot0_aux_io_enable_out
);

    logic [7:0] gen_ctrl;
    logic [7:0] next_gen_ctrl;
    logic [31:0] alias_reg;
    logic [31:0] next_alias_reg;
    logic [31:0] socket;
    logic [31:0] next_socket;
    logic [31:0] rdata;
    logic [31:0] next_rdata;
    logic ack;
    logic next_ack;
    logic [1:0] route;
    logic [1:0] next_route;
    logic [STRAP_COUNT-1:0] strap_level;
    logic strap_any;
    logic present_level;
    logic [31:0] be_mask;
    logic [7:0] dword_addr;

    // Strap pins come from the board, so they are filtered first
    scpcr_pin_sync #(
        .WIDTH(STRAP_COUNT)
    ) u_strap_sync (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .pin_in(interrupt_strap_pins_in),
        .level_out(strap_level)
    );

    // Card detect is a pin as well
    scpcr_pin_sync #(
        .WIDTH(1)
    ) u_present_sync (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .pin_in(card_present_in),
        .level_out(present_level)
    );

    // Insertion wake request
    scpcr_insert_wake u_insert_wake (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .present_in(present_level),
        .wake_enable_in(socket[SOCK_INS_WAKE_BIT]),
        .wake_out(pme_wake_out)
    );

    // Byte enables widened to a bit mask; address reduced to its dword
    assign be_mask = {{8{cfg_req_in.be[3]}}, {8{cfg_req_in.be[2]}},
                      {8{cfg_req_in.be[1]}}, {8{cfg_req_in.be[0]}}};
    assign dword_addr = {cfg_req_in.addr[7:2], 2'b00};
    assign strap_any = |strap_level;

    // Register writes; masks keep read-only bits at zero
    always_comb begin
        next_gen_ctrl = gen_ctrl;
        next_alias_reg = alias_reg;
        next_socket = socket;
        if (cfg_req_in.wr) begin
            case (dword_addr)
                OFS_GEN_CTRL: begin
                    // Only bits 6:4 take data; bit 7 and 3:0 stay zero
                    next_gen_ctrl = (gen_ctrl & ~(GEN_CTRL_WMASK & be_mask[7:0]))
                        | (cfg_req_in.wdata[7:0] & GEN_CTRL_WMASK & be_mask[7:0]);
                end
                OFS_ALIAS: begin
                    // Each byte lane updates on its own enable
                    next_alias_reg = (alias_reg & ~be_mask)
                        | (cfg_req_in.wdata & be_mask);
                end
                OFS_SOCKET: begin
                    next_socket = (socket & ~(SOCKET_WMASK & be_mask))
                        | (cfg_req_in.wdata & SOCKET_WMASK & be_mask);
                end
                default: begin
                    // The PM dword and anything else ignore writes
                    next_gen_ctrl = gen_ctrl;
                end
            endcase
        end
    end

    // Storage is cleared only by the global hard reset pin
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            gen_ctrl <= GEN_CTRL_RESET;
            alias_reg <= ALIAS_RESET;
            socket <= SOCKET_RESET;
        end else begin
            gen_ctrl <= next_gen_ctrl;
            alias_reg <= next_alias_reg;
            socket <= next_socket;
        end
    end

    // Read data; the read sees the value before a same-cycle write
    always_comb begin
        next_rdata = 32'h0000_0000;
        next_ack = cfg_req_in.rd || cfg_req_in.wr;
        if (cfg_req_in.rd) begin
            case (dword_addr)
                OFS_BOARD_IDS: begin
                    next_rdata = alias_reg;
                end
                OFS_PM_DWORD: begin
                    // Lanes of 4Ah and 4Bh are constant zero
                    next_rdata = 32'h0000_0000;
                end
                OFS_GEN_CTRL: begin
                    next_rdata = {24'h00_0000, gen_ctrl & GEN_CTRL_WMASK};
                end
                OFS_ALIAS: begin
                    next_rdata = alias_reg;
                end
                OFS_SOCKET: begin
                    next_rdata = socket & SOCKET_WMASK;
                end
                default: begin
                    next_rdata = 32'h0000_0000;
                end
            endcase
        end
    end

    // Interrupt output choice; lowest asserted strap wins over the field
    always_comb begin
        next_route = gen_ctrl[GEN_INT_SEL_LSB +: 2];
        if (strap_any) begin
            next_route = 2'h0;
            for (int i = STRAP_COUNT - 1; i >= 0; i--) begin
                if (strap_level[i]) begin
                    next_route = i[1:0];
                end
            end
        end
    end

    // Answer and routing registers
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rdata <= 32'h0000_0000;
            ack <= 1'b0;
            route <= 2'h0;
        end else begin
            rdata <= next_rdata;
            ack <= next_ack;
            route <= next_route;
        end
    end

    // Outputs, all from flip-flops or constant decodes of them
    assign cfg_rsp_out.ack = ack;
    assign cfg_rsp_out.rdata = rdata;
    assign int_route_out = route;
    assign interrupt_pin_reg_out = INT_PIN_BASE + {6'h00, route};
    assign cold_wake_flag_out = gen_ctrl[GEN_COLD_WAKE_BIT];
    assign aux_current_out = gen_ctrl[GEN_COLD_WAKE_BIT] ?
        AUX_CURRENT_55MA : AUX_CURRENT_SELF;
    assign board_vendor_field_out = alias_reg[ALIAS_VENDOR_LSB +: 16];
    assign board_device_field_out = alias_reg[ALIAS_DEVICE_LSB +: 16];
    assign slot0_enable_out = socket[SOCK_ENABLE_BIT];
    assign slot0_class_a_support_out = socket[SOCK_CLASS_A_BIT];
    assign slot0_class_b_support_out = socket[SOCK_CLASS_B_BIT];
    assign slot0_payment_iface_enable_out = socket[SOCK_PAY_IF_BIT];
    assign slot0_aux_io_enable_out = socket[SOCK_AUX_IO_BIT];

    // Checks on the register behaviour
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);

    a_pm_ext_zero: assert property (
        (cfg_req_in.rd && dword_addr == OFS_PM_DWORD) |=> rdata[23:16] == 8'h00)
        else $error("bridge extension byte read non-zero");
    a_pm_data_zero: assert property (
        (cfg_req_in.rd && dword_addr == OFS_PM_DWORD) |=> rdata[31:24] == 8'h00)
        else $error("power data byte read non-zero");
    a_genctl_rsvd_zero: assert property (
        (cfg_req_in.rd && dword_addr == OFS_GEN_CTRL) |=> (rdata & 32'hffff_ff8f) == 32'h0)
        else $error("general control reserved bits read non-zero");
    a_route_from_field: assert property (
        !strap_any |=> int_route_out == $past(gen_ctrl[6:5]))
        else $error("interrupt route does not follow select field");
    a_strap_overrides: assert property (
        (strap_level == 4'h4) |=> int_route_out == 2'h2 && interrupt_pin_reg_out == 8'h03)
        else $error("strap did not override interrupt select");
    a_cold_flag_write: assert property (
        (cfg_req_in.wr && dword_addr == OFS_GEN_CTRL && cfg_req_in.be[0])
        |=> cold_wake_flag_out == $past(cfg_req_in.wdata[4]))
        else $error("cold wake flag did not follow write");
    a_alias_device: assert property (
        (cfg_req_in.wr && dword_addr == OFS_ALIAS && cfg_req_in.be[3:2] == 2'h3)
        |=> board_device_field_out == $past(cfg_req_in.wdata[31:16]))
        else $error("board device field not updated");
    a_alias_vendor: assert property (
        (cfg_req_in.wr && dword_addr == OFS_ALIAS && cfg_req_in.be[1:0] == 2'h3)
        ##1 cfg_req_in.rd && dword_addr == OFS_BOARD_IDS && !cfg_req_in.wr
        |=> rdata[15:0] == $past(cfg_req_in.wdata[15:0], 2))
        else $error("vendor alias not returned at 2Ch");
    a_socket_rsvd: assert property (
        (socket & ~SOCKET_WMASK) == 32'h0)
        else $error("socket read-only bits became set");
    a_aux_current: assert property (
        aux_current_out == (cold_wake_flag_out ? 3'h1 : 3'h0))
        else $error("aux current does not match cold wake flag");

    // Handshake and byte lane checks
    a_ack_follows_req: assert property (
        (cfg_req_in.rd || cfg_req_in.wr) |=> cfg_rsp_out.ack)
        else $error("request not acknowledged");
    a_ack_needs_req: assert property (
        cfg_rsp_out.ack |-> $past(cfg_req_in.rd) || $past(cfg_req_in.wr))
        else $error("acknowledge without request");
    a_genctl_lane_off: assert property (
        (cfg_req_in.wr && dword_addr == OFS_GEN_CTRL && !cfg_req_in.be[0])
        |=> $stable(gen_ctrl))
        else $error("general control changed with its lane off");

    // Storage moves only on its own write; nothing but the hard reset clears it
    a_genctl_bits_zero: assert property (
        (gen_ctrl & ~GEN_CTRL_WMASK) == 8'h00)
        else $error("general control reserved bit set");
    a_cold_flag_hold: assert property (
        !(cfg_req_in.wr && dword_addr == OFS_GEN_CTRL) |=> $stable(cold_wake_flag_out))
        else $error("cold wake flag changed without a write");
    a_alias_hold: assert property (
        !(cfg_req_in.wr && dword_addr == OFS_ALIAS) |=> $stable(alias_reg))
        else $error("alias changed without a write");
    a_socket_hold: assert property (
        !(cfg_req_in.wr && dword_addr == OFS_SOCKET) |=> $stable(socket))
        else $error("socket configuration changed without a write");

    // Read-back and routing decode
    a_ids_read: assert property (
        (cfg_req_in.rd && dword_addr == OFS_BOARD_IDS)
        |=> cfg_rsp_out.rdata == {board_device_field_out, board_vendor_field_out})
        else $error("board id read differs from the board fields");
    a_socket_read: assert property (
        (cfg_req_in.rd && dword_addr == OFS_SOCKET)
        |=> (cfg_rsp_out.rdata & ~SOCKET_WMASK) == 32'h0)
        else $error("socket read shows a read-only bit");
    a_pin_reg_d: assert property (
        (int_route_out == 2'h3) |-> interrupt_pin_reg_out == 8'h04)
        else $error("route D did not program pin register 4");
    a_strap_lowest: assert property (
        strap_level[0] |=> int_route_out == 2'h0)
        else $error("strap A did not select output A");

    // Each socket bit follows a write to its own byte lane
    a_slot_enable_wr: assert property (
        (cfg_req_in.wr && dword_addr == OFS_SOCKET && cfg_req_in.be[0])
        |=> slot0_enable_out == $past(cfg_req_in.wdata[SOCK_ENABLE_BIT]))
        else $error("socket enable did not follow write");
    a_ins_wake_wr: assert property (
        (cfg_req_in.wr && dword_addr == OFS_SOCKET && cfg_req_in.be[0])
        |=> socket[SOCK_INS_WAKE_BIT] == $past(cfg_req_in.wdata[SOCK_INS_WAKE_BIT]))
        else $error("insertion wake bit did not follow write");
    a_aux_io_wr: assert property (
        (cfg_req_in.wr && dword_addr == OFS_SOCKET && cfg_req_in.be[1])
        |=> slot0_aux_io_enable_out == $past(cfg_req_in.wdata[SOCK_AUX_IO_BIT]))
        else $error("aux io enable did not follow write");
    a_pay_if_wr: assert property (
        (cfg_req_in.wr && dword_addr == OFS_SOCKET && cfg_req_in.be[2])
        |=> slot0_payment_iface_enable_out == $past(cfg_req_in.wdata[SOCK_PAY_IF_BIT]))
        else $error("payment interface enable did not follow write");
    a_class_a_wr: assert property (
        (cfg_req_in.wr && dword_addr == OFS_SOCKET && cfg_req_in.be[2])
        |=> slot0_class_a_support_out == $past(cfg_req_in.wdata[SOCK_CLASS_A_BIT]))
        else $error("class A support did not follow write");
    a_class_b_wr: assert property (
        (cfg_req_in.wr && dword_addr == OFS_SOCKET && cfg_req_in.be[3])
        |=> slot0_class_b_support_out == $past(cfg_req_in.wdata[SOCK_CLASS_B_BIT]))
        else $error("class B support did not follow write");

    c_socket_write: cover property (cfg_req_in.wr && dword_addr == OFS_SOCKET);
    c_genctl_read: cover property (cfg_req_in.rd && dword_addr == OFS_GEN_CTRL);
    c_strap_route: cover property (strap_any && gen_ctrl[6:5] != 2'h0);
    c_alias_read: cover property (cfg_req_in.rd && dword_addr == OFS_BOARD_IDS);

endmodule
`default_nettype wire

// file: verif/scpcr_host_model.sv
// Host bridge model issuing configuration read and write cycles
`timescale 1ns/100ps
`default_nettype none
module scpcr_host_model
    import scpcr_pkg::*;
(
    // Clock
    input wire logic clk_in,
    // Configuration cycle port
    output scpcr_cfg_req_s cfg_req_out,
    input wire scpcr_cfg_rsp_s cfg_rsp_in
);
    // Idle bus at time zero
    initial begin
        cfg_req_out = '0;
    end

    // One configuration cycle, request for one taking edge, then wait for ack
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [3:0] be,
                        input logic [31:0] d, output logic [31:0] q, output logic ok);
        int n;
        ok = 1'b0;
        q = '0;
        @(negedge clk_in);
        cfg_req_out.wr = wr;
        cfg_req_out.rd = !wr;
        cfg_req_out.addr = a;
        cfg_req_out.be = be;
        cfg_req_out.wdata = d;
        @(posedge clk_in);
        @(negedge clk_in);
        // Released lines show garbage, not the last value
        cfg_req_out.wr = 1'b0;
        cfg_req_out.rd = 1'b0;
        cfg_req_out.addr = ~a;
        cfg_req_out.be = ~be;
        cfg_req_out.wdata = ~d;
        for (n = 0; n < 4 && !ok; n++) begin
            if (cfg_rsp_in.ack === 1'b1) begin
                ok = 1'b1;
                q = cfg_rsp_in.rdata;
            end else begin
                @(negedge clk_in);
            end
        end
    endtask

    // Write, then a read at the very next edge, as back-to-back cycles allow
    task automatic wr_rd(input logic [7:0] wa, input logic [31:0] d, input logic [7:0] ra,
                         output logic [31:0] q, output logic ok);
        @(negedge clk_in);
        cfg_req_out.wr = 1'b1;
        cfg_req_out.rd = 1'b0;
        cfg_req_out.addr = wa;
        cfg_req_out.be = 4'hf;
        cfg_req_out.wdata = d;
        @(negedge clk_in);
        // Write answered here while the read goes out
        ok = (cfg_rsp_in.ack === 1'b1);
        cfg_req_out.wr = 1'b0;
        cfg_req_out.rd = 1'b1;
        cfg_req_out.addr = ra;
        cfg_req_out.wdata = ~d;
        @(negedge clk_in);
        ok = ok && (cfg_rsp_in.ack === 1'b1);
        q = cfg_rsp_in.rdata;
        cfg_req_out.rd = 1'b0;
        cfg_req_out.addr = ~ra;
        cfg_req_out.be = 4'h0;
    endtask
endmodule
`default_nettype wire

// file: verif/tb_top.sv
// Self-checking bench for the smart card configuration registers
`timescale 1ns/100ps
`default_nettype none
module tb_top
    import scpcr_pkg::*;
;
    typedef struct {
        logic wr;
        logic [7:0] addr;
        logic [3:0] be;
        logic [31:0] data;
    } scpcr_row_s;
    logic clk_in;
    logic rst_n_in;
    scpcr_cfg_req_s cfg_req;
    scpcr_cfg_rsp_s cfg_rsp;
    logic [STRAP_COUNT-1:0] straps;
    logic present;
    logic [1:0] route;
    logic [7:0] pin_reg;
    logic cold_flag, pme, s_en, s_a, s_b, s_pay, s_aux;
    logic [2:0] aux_cur;
    logic [15:0] vendor, device;
    int fails = 0;
    int n_compared = 0;
    // Reads expect data, writes carry data; one pass covers lanes and masks
    scpcr_row_s rows[21] = '{
        '{0, 8'h4c, 4'hf, 32'h0}, '{0, 8'h58, 4'hf, 32'h0011_0001},
        '{0, 8'h50, 4'hf, 32'h0}, '{0, 8'h48, 4'hf, 32'h0},
        '{1, 8'h48, 4'hf, 32'hffff_ffff}, '{0, 8'h48, 4'hf, 32'h0},
        '{1, 8'h4c, 4'h1, 32'hffff_ffff}, '{0, 8'h4c, 4'hf, 32'h70},
        '{1, 8'h4c, 4'he, 32'h0}, '{0, 8'h4c, 4'hf, 32'h70},
        '{1, 8'h58, 4'hf, 32'hffff_ffff}, '{0, 8'h58, 4'hf, 32'hf111_1011},
        '{1, 8'h58, 4'hf, 32'h0}, '{0, 8'h58, 4'hf, 32'h0},
        '{1, 8'h50, 4'h3, 32'h1234_5678}, '{0, 8'h50, 4'hf, 32'h0000_5678},
        '{1, 8'h50, 4'hc, 32'habcd_0000}, '{0, 8'h50, 4'hf, 32'habcd_5678},
        '{0, 8'h2c, 4'hf, 32'habcd_5678}, '{1, 8'h60, 4'hf, 32'hffff_ffff},
        '{0, 8'h60, 4'hf, 32'h0}};

    scpcr_host_model i_host (.clk_in(clk_in), .cfg_req_out(cfg_req), .cfg_rsp_in(cfg_rsp));

    scpcr_top i_dut (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .cfg_req_in(cfg_req), .cfg_rsp_out(cfg_rsp),
        .interrupt_strap_pins_in(straps), .card_present_in(present),
        .int_route_out(route), .interrupt_pin_reg_out(pin_reg),
        .cold_wake_flag_out(cold_flag), .aux_current_out(aux_cur), .pme_wake_out(pme),
        .board_vendor_field_out(vendor), .board_device_field_out(device),
        .slot0_enable_out(s_en), .slot0_class_a_support_out(s_a),
        .slot0_class_b_support_out(s_b), .slot0_payment_iface_enable_out(s_pay),
        .slot0_aux_io_enable_out(s_aux));

    // Free-running 100 MHz clock
    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end

    // Verdict in one place
    task automatic complete_run();
        $display("compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Bus cycle; a lost ack is a mismatch and ends the run
    task automatic access(input logic wr, input logic [7:0] a, input logic [3:0] be,
                          input logic [31:0] d, output logic [31:0] q);
        logic ok;
        i_host.xfer(wr, a, be, d, q, ok);
        if (!ok) begin
            check("ack", {31'h0, ok}, 32'h1);
            complete_run();
        end
    endtask

    // Slot outputs packed as b, a, pay, aux, wake-free, enable
    task automatic check_slots(input logic [4:0] exp);
        check("slot outputs", {27'h0, s_b, s_a, s_pay, s_aux, s_en}, {27'h0, exp});
    endtask

    // Count wake pulses over a bounded window after an insertion
    task automatic insert_and_count(output int pulses);
        pulses = 0;
        @(negedge clk_in);
        present = 1'b1;
        repeat (20) begin
            @(negedge clk_in);
            if (pme === 1'b1) pulses++;
        end
        present = 1'b0;
        repeat (10) @(negedge clk_in);
    endtask

    task automatic wait_route(input logic [1:0] exp);
        int n;
        for (n = 0; n < 20 && route !== exp; n++) @(negedge clk_in);
    endtask

    initial begin
        logic [31:0] q;
        int pulses;
        logic ok;
        rst_n_in = 1'b0;
        straps = '0;
        present = 1'b0;
        repeat (4) @(posedge clk_in);
        @(negedge clk_in);
        rst_n_in = 1'b1;
        check_slots(5'b01101);
        // Table of ordinary register accesses
        foreach (rows[i]) begin
            access(rows[i].wr, rows[i].addr, rows[i].be, rows[i].data, q);
            if (!rows[i].wr) check("row read", q, rows[i].data);
        end
        check("ids", {device, vendor}, 32'habcd_5678);
        check_slots(5'b00000);
        // Every interrupt select code, cold wake bit toggling
        for (int i = 0; i < 4; i++) begin
            access(1'b1, 8'h4c, 4'h1, 32'(i * 32 + (i % 2) * 16), q);
            @(negedge clk_in); // Route register lags the field by one edge
            check("route", {30'h0, route}, 32'(i));
            check("pin reg", {24'h0, pin_reg}, 32'(i + 1));
            check("cold flag", {31'h0, cold_flag}, 32'(i[0]));
            check("aux current", {29'h0, aux_cur}, 32'(i[0]));
        end
        // Strap overrides select field
        access(1'b1, 8'h4c, 4'h1, 32'h20, q);
        @(negedge clk_in);
        straps = 4'b0100;
        wait_route(2'h2);
        check("strap route", {30'h0, route}, 32'h2);
        check("strap pin reg", {24'h0, pin_reg}, 32'h3);
        straps = 4'b0101;
        wait_route(2'h0);
        check("lowest strap", {30'h0, route}, 32'h0);
        straps = '0;
        wait_route(2'h1);
        check("released route", {30'h0, route}, 32'h1);
        // Insertion wake enabled then disabled
        access(1'b1, 8'h58, 4'hf, 32'hffff_ffff, q);
        check_slots(5'b11111);
        insert_and_count(pulses);
        check("wake pulses", 32'(pulses), 32'h1);
        access(1'b1, 8'h58, 4'hf, 32'h0011_0001, q);
        insert_and_count(pulses);
        check("masked wake", 32'(pulses), 32'h0);
        // Hard reset in mid-run restores every field
        access(1'b1, 8'h58, 4'hf, 32'hf000_1010, q);
        @(negedge clk_in);
        rst_n_in = 1'b0;
        repeat (2) @(negedge clk_in);
        rst_n_in = 1'b1;
        check_slots(5'b01101);
        access(1'b0, 8'h4c, 4'hf, 32'h0, q);
        check("ctrl after reset", q, 32'h0);
        access(1'b0, 8'h58, 4'hf, 32'h0, q);
        check("socket after reset", q, 32'h0011_0001);
        access(1'b0, 8'h50, 4'hf, 32'h0, q);
        check("alias after reset", q, 32'h0);
        check("flag after reset", {29'h0, cold_flag, aux_cur[1:0]}, 32'h0);
        // Write then read on the next edge; the read returns the new alias
        i_host.wr_rd(8'h50, 32'h2468_1357, 8'h2c, q, ok);
        check("burst ack", {31'h0, ok}, 32'h1);
        check("burst read", q, 32'h2468_1357);
        complete_run();
    end
endmodule
`default_nettype wire
